// file: pis_regs.vh
`ifndef PIS_REGS_VH
`define PIS_REGS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define PIS_ADDR_SCAN_CTRL   12'h000
`define PIS_ADDR_IN_IMAGE    12'h004
`define PIS_ADDR_OUT_COIL    12'h008
`define PIS_ADDR_SPECIAL     12'h00C
`define PIS_ADDR_IRQ_SERVICE 12'h010
`define PIS_ADDR_JUMP        12'h014
`define PIS_ADDR_LABEL       12'h018
`define PIS_ADDR_RELAY_BASE  12'h020
`define PIS_ADDR_RELAY_LAST  12'h02C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PIS_CTRL_END_BIT     0
`define PIS_CTRL_STEP_BIT    1
`define PIS_COIL_IDX_LSB     0
`define PIS_COIL_VAL_BIT     8
`define PIS_SPC_INIT_BIT     8
`define PIS_SPC_FAULT_BIT    9
`define PIS_SPC_REBOOT_BIT   10
`define PIS_LABEL_VAL_LSB    16

// ----------------------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------------------
`define PIS_IO_LINES         8
`define PIS_LABELS           32
`define PIS_RELAY_WORDS      4
`define PIS_LINE_W           16
`define PIS_LINE_ZERO        16'h0000
`define PIS_OUT_RESET        8'h00
`define PIS_WORD_ZERO        32'h0000_0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PIS_CLK_PERIOD_NS    8
`define PIS_INIT_TIME_NS     10000
`define PIS_INIT_CYC         (`PIS_INIT_TIME_NS / `PIS_CLK_PERIOD_NS)
`define PIS_INIT_CNT_W       11
// Last count of the init wait, one below PIS_INIT_CYC
`define PIS_INIT_LAST        11'h4E1

`endif

// file: pis_in_image.v
`timescale 1ns/1ns
`include "pis_regs.vh"

module pis_in_image (
  input  wire       clk_sys,
  input  wire       reset,
  input  wire       sample_stb,
  input  wire       irq_stb,
  input  wire [2:0] irq_line,
  input  wire [7:0] field_sense_pads,
  output reg  [7:0] in_image_ff,
  output wire [7:0] irq_line_snapshot_relays
);

  // --------------------------------------------------------------------------
  // Input image
  // --------------------------------------------------------------------------
  // Level at the sampling edge only; pulses between samples are not seen
  always @(posedge clk_sys) begin
    if (reset) begin
      in_image_ff <= `PIS_OUT_RESET;
    end else if (sample_stb) begin
      in_image_ff <= field_sense_pads;
    end
  end

  // --------------------------------------------------------------------------
  // Snapshot relays, one per interrupt line
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PIS_IO_LINES; g = g + 1) begin : g_snap
      reg snap_ff;
      always @(posedge clk_sys) begin
        if (reset) begin
          snap_ff <= 1'b0;
        end else if (irq_stb && (irq_line == g)) begin
          snap_ff <= field_sense_pads[g];
        end
      end
      assign irq_line_snapshot_relays[g] = snap_ff;
    end
  endgenerate

endmodule // pis_in_image

// file: pis_out_image.v
`timescale 1ns/1ns
`include "pis_regs.vh"

module pis_out_image (
  input  wire       clk_sys,
  input  wire       reset,
  input  wire       coil_stb,
  input  wire [2:0] coil_idx,
  input  wire       coil_val,
  input  wire       xfer_stb,
  output reg  [7:0] out_image_ff,
  output reg  [7:0] out_contacts_ff
);

  // --------------------------------------------------------------------------
  // Output image and transfer
  // --------------------------------------------------------------------------
  reg [7:0] nxt_out_image;

  always @* begin
    nxt_out_image = out_image_ff;
    if (coil_stb) begin
      nxt_out_image[coil_idx] = coil_val;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      out_image_ff    <= `PIS_OUT_RESET;
      out_contacts_ff <= `PIS_OUT_RESET;
    end else begin
      out_image_ff <= nxt_out_image;
      if (xfer_stb) begin
        out_contacts_ff <= out_image_ff;
      end
    end
  end

endmodule // pis_out_image

// file: pis_top.v
// Behaviour
// - I/O lines are numbered in octal; only indices 0 to 7 exist.
// - Each scan starts by latching all physical inputs into the input image.
// - Input pulses shorter than a scan may be missed; sampled level counts.
// - Program runs from line zero each scan; operand states kept in memory.
// - Output image reaches physical outputs only after the terminator, once per scan.
// - Several writes to one coil in a scan: the last write decides.
// - On servicing interrupt line n, its snapshot relay takes input pad n.
// - Interrupt servicing never touches the input image; next scan refreshes it.
// - Init-done relay rises when peripheral init ends and then stays high until cleared.
// - Clearing init-done re-initializes the peripherals.
// - Fault-lamp relay set lights the error lamp; cleared turns it off.
// - Reboot request set, then init-done cleared, gives a full reboot.
// - Internal relays numbered decimally and cleared on power loss.
// - Thirty-two label pointers serve as call and jump targets.
`timescale 1ns/1ns
`include "pis_regs.vh"

module pis_top (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [7:0]  field_sense_pads,
  output wire [7:0]  out_contacts,
  output reg         fault_lamp,
  output reg         periph_reinit,
  output reg         reboot_pulse,
  output reg         init_done
);

  // --------------------------------------------------------------------------
  // Scan states
  // --------------------------------------------------------------------------
  localparam [1:0] ST_INIT   = 2'b00;
  localparam [1:0] ST_SAMPLE = 2'b01;
  localparam [1:0] ST_RUN    = 2'b10;
  localparam [1:0] ST_XFER   = 2'b11;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  reg  [1:0]                 state_ff;
  reg  [1:0]                 nxt_state;
  reg  [`PIS_LINE_W-1:0]     line_ff;
  reg  [`PIS_LINE_W-1:0]     nxt_line;
  reg  [`PIS_INIT_CNT_W-1:0] init_cnt_ff;
  reg                        init_done_ff;
  reg                        fault_ff;
  reg                        reboot_req_ff;
  reg                        reboot_ff;
  reg  [`PIS_LINE_W-1:0]     label_mem [0:`PIS_LABELS-1];
  reg  [31:0]                relay_mem [0:`PIS_RELAY_WORDS-1];
  reg  [4:0]                 label_sel_ff;
  reg  [31:0]                nxt_rdata;
  reg                        nxt_err;
  wire                       wr_acc;
  wire                       soft_rst;
  wire                       sample_stb;
  wire                       xfer_stb;
  wire                       coil_stb;
  wire                       irq_stb;
  wire                       clr_init;
  wire [7:0]                 in_image;
  wire [7:0]                 snap_relays;
  wire [7:0]                 out_image;
  integer                    i;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  // Relay words sit at four consecutive aligned addresses
  function is_relay;
    input [11:0] a;
    begin
      is_relay = (a >= `PIS_ADDR_RELAY_BASE) && (a <= `PIS_ADDR_RELAY_LAST) &&
                 (a[1:0] == 2'b00);
    end
  endfunction

  function hit;
    input [11:0] a;
    input [11:0] reg_addr;
    begin
      hit = (a == reg_addr);
    end
  endfunction

  // A write takes effect only at the access edge with pready high
  assign wr_acc     = psel & penable & pready & pwrite;
  // Full reboot clears the block like power-on, except the APB response flops, reboot_ff and the fault_lamp, reboot_pulse and init_done flops
  assign soft_rst   = reset | reboot_ff;
  assign sample_stb = (state_ff == ST_SAMPLE);
  assign xfer_stb   = (state_ff == ST_XFER);
  // Coil writes are only meaningful while the program is running
  assign coil_stb   = wr_acc & hit(paddr, `PIS_ADDR_OUT_COIL) & (state_ff == ST_RUN);
  assign irq_stb    = wr_acc & hit(paddr, `PIS_ADDR_IRQ_SERVICE);
  assign clr_init   = wr_acc & hit(paddr, `PIS_ADDR_SPECIAL) & init_done_ff &
                      ~pwdata[`PIS_SPC_INIT_BIT];

  // --------------------------------------------------------------------------
  // Image submodules
  // --------------------------------------------------------------------------
  pis_in_image pis_in_image_i (
    .clk_sys                  (clk_sys),
    .reset                    (soft_rst),
    .sample_stb               (sample_stb),
    .irq_stb                  (irq_stb),
    .irq_line                 (pwdata[2:0]),
    .field_sense_pads         (field_sense_pads),
    .in_image_ff              (in_image),
    .irq_line_snapshot_relays (snap_relays)
  );

  pis_out_image pis_out_image_i (
    .clk_sys         (clk_sys),
    .reset           (soft_rst),
    .coil_stb        (coil_stb),
    .coil_idx        (pwdata[`PIS_COIL_IDX_LSB +: 3]),
    .coil_val        (pwdata[`PIS_COIL_VAL_BIT]),
    .xfer_stb        (xfer_stb),
    .out_image_ff    (out_image),
    .out_contacts_ff (out_contacts)
  );

  // --------------------------------------------------------------------------
  // Scan sequencer
  // --------------------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    nxt_line  = line_ff;
    case (state_ff)
      ST_INIT: begin
        if (init_cnt_ff == `PIS_INIT_LAST) begin
          nxt_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        nxt_state = ST_RUN;
        nxt_line  = `PIS_LINE_ZERO;
      end
      ST_RUN: begin
        if (wr_acc && hit(paddr, `PIS_ADDR_SCAN_CTRL) && pwdata[`PIS_CTRL_END_BIT]) begin
          nxt_state = ST_XFER;
        end else if (wr_acc && hit(paddr, `PIS_ADDR_SCAN_CTRL) && pwdata[`PIS_CTRL_STEP_BIT]) begin
          nxt_line = line_ff + 16'h0001;
        end else if (wr_acc && hit(paddr, `PIS_ADDR_JUMP)) begin
          nxt_line = label_mem[pwdata[4:0]];
        end
      end
      default: begin
        nxt_state = ST_SAMPLE;
      end
    endcase
    // Re-initialization parks the scan until the peripherals are ready again
    if (clr_init) begin
      nxt_state = ST_INIT;
    end
  end

  always @(posedge clk_sys) begin
    if (soft_rst) begin
      state_ff <= ST_INIT;
      line_ff  <= `PIS_LINE_ZERO;
    end else begin
      state_ff <= nxt_state;
      line_ff  <= nxt_line;
    end
  end

  // --------------------------------------------------------------------------
  // Peripheral init and special relays
  // --------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (soft_rst) begin
      init_cnt_ff   <= {`PIS_INIT_CNT_W{1'b0}};
      init_done_ff  <= 1'b0;
      fault_ff      <= 1'b0;
      reboot_req_ff <= 1'b0;
      periph_reinit <= 1'b0;
    end else begin
      periph_reinit <= 1'b0;
      if (clr_init) begin
        init_done_ff <= 1'b0;
        init_cnt_ff  <= {`PIS_INIT_CNT_W{1'b0}};
        // Reinit only when no reboot was requested; reboot wins otherwise
        periph_reinit <= ~reboot_req_ff;
      end else if (state_ff == ST_INIT) begin
        if (init_cnt_ff == `PIS_INIT_LAST) begin
          init_done_ff <= 1'b1;
        end else begin
          init_cnt_ff <= init_cnt_ff + 1'b1;
        end
      end
      if (wr_acc && hit(paddr, `PIS_ADDR_SPECIAL)) begin
        fault_ff      <= pwdata[`PIS_SPC_FAULT_BIT];
        reboot_req_ff <= pwdata[`PIS_SPC_REBOOT_BIT];
      end
    end
  end

  // Reboot pulse is a plain flop so it can itself clear the block next cycle
  always @(posedge clk_sys) begin
    if (reset) begin
      reboot_ff <= 1'b0;
    end else begin
      reboot_ff <= clr_init & reboot_req_ff & ~reboot_ff;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      fault_lamp   <= 1'b0;
      reboot_pulse <= 1'b0;
      init_done    <= 1'b0;
    end else begin
      fault_lamp   <= fault_ff;
      reboot_pulse <= reboot_ff;
      init_done    <= init_done_ff;
    end
  end

  // --------------------------------------------------------------------------
  // Operand memory: labels and internal relays
  // --------------------------------------------------------------------------
  // Relays are volatile: any reset or reboot clears them
  always @(posedge clk_sys) begin
    if (soft_rst) begin
      for (i = 0; i < `PIS_RELAY_WORDS; i = i + 1) begin
        relay_mem[i] <= `PIS_WORD_ZERO;
      end
      for (i = 0; i < `PIS_LABELS; i = i + 1) begin
        label_mem[i] <= `PIS_LINE_ZERO;
      end
      label_sel_ff <= 5'h00;
    end else begin
      if (wr_acc && is_relay(paddr)) begin
        relay_mem[paddr[3:2]] <= pwdata;
      end
      if (wr_acc && hit(paddr, `PIS_ADDR_LABEL)) begin
        label_sel_ff <= pwdata[4:0];
        label_mem[pwdata[4:0]] <= pwdata[`PIS_LABEL_VAL_LSB +: `PIS_LINE_W];
      end
    end
  end

  // --------------------------------------------------------------------------
  // APB read mux
  // --------------------------------------------------------------------------
  always @* begin
    nxt_rdata = `PIS_WORD_ZERO;
    nxt_err   = 1'b0;
    if (hit(paddr, `PIS_ADDR_SCAN_CTRL)) begin
      nxt_rdata = {line_ff, 14'h0000, state_ff};
    end else if (hit(paddr, `PIS_ADDR_IN_IMAGE)) begin
      nxt_rdata = {24'h00_0000, in_image};
    end else if (hit(paddr, `PIS_ADDR_OUT_COIL)) begin
      nxt_rdata = {16'h0000, out_contacts, out_image};
    end else if (hit(paddr, `PIS_ADDR_SPECIAL)) begin
      nxt_rdata = {21'h00_0000, reboot_req_ff, fault_ff, init_done_ff, snap_relays};
    end else if (hit(paddr, `PIS_ADDR_IRQ_SERVICE) || hit(paddr, `PIS_ADDR_JUMP)) begin
      nxt_rdata = `PIS_WORD_ZERO;
    end else if (hit(paddr, `PIS_ADDR_LABEL)) begin
      nxt_rdata = {label_mem[label_sel_ff], 11'h000, label_sel_ff};
    end else if (is_relay(paddr)) begin
      nxt_rdata = relay_mem[paddr[3:2]];
    end else begin
      nxt_err = 1'b1;
    end
  end

  // One wait-free access: pready rises for the cycle after setup
  always @(posedge clk_sys) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= `PIS_WORD_ZERO;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      if (psel && !penable) begin
        prdata  <= pwrite ? `PIS_WORD_ZERO : nxt_rdata;
        pslverr <= nxt_err;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule // pis_top

// file: pis_top_sva.sv
`timescale 1ns/1ns
`include "pis_regs.vh"

module pis_top_chk (
  input wire        clk_sys,
  input wire        reset,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [7:0]  field_sense_pads,
  input wire [7:0]  out_contacts,
  input wire        fault_lamp,
  input wire        periph_reinit,
  input wire        reboot_pulse,
  input wire        init_done
);
  localparam int INIT_LO = `PIS_INIT_CYC - 8;
  localparam int INIT_HI = `PIS_INIT_CYC + 8;
  wire       acc = psel && penable && pready;
  wire       spc = acc && pwrite && paddr == `PIS_ADDR_SPECIAL;
  wire       clr = spc && !pwdata[`PIS_SPC_INIT_BIT] && init_done;
  wire       fin = acc && pwrite && paddr == `PIS_ADDR_SCAN_CTRL && pwdata[0];
  wire       low = paddr <= `PIS_ADDR_LABEL;
  wire       rly = paddr >= `PIS_ADDR_RELAY_BASE && paddr <= `PIS_ADDR_RELAY_LAST;
  wire       mapped = paddr[1:0] == 2'b00 && (low || rly);
  reg  [3:0]  hist_ff;
  reg  [11:0] low_cnt_ff;

  // ----
  // Recent scan ends or reboots; contacts may only move shortly after one
  // ----
  always @(posedge clk_sys) begin
    if (reset) begin
      hist_ff    <= 4'h0;
      low_cnt_ff <= 12'h000;
    end else begin
      hist_ff    <= {hist_ff[2:0], fin || reboot_pulse};
      low_cnt_ff <= init_done ? 12'h000 : low_cnt_ff + 12'h001;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_ready_next: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready) else $error("ready held too long");
  a_err_map: assert property (pready |-> pslverr == !mapped) else $error("slave error wrong");
  a_reset_dark: assert property (disable iff (1'b0) reset |=> out_contacts == 8'h00)
    else $error("contacts not cleared");
  a_contact_xfer: assert property ($changed(out_contacts) |-> |hist_ff || reboot_pulse)
    else $error("contacts moved without scan end");
  a_lamp_on: assert property (spc && pwdata[9] && pwdata[8] |-> ##[1:2] fault_lamp)
    else $error("lamp not lit");
  a_lamp_off: assert property (spc && !pwdata[9] |-> ##[1:2] !fault_lamp)
    else $error("lamp not off");
  a_reinit_why: assert property (periph_reinit |-> $past(clr))
    else $error("reinit without clear");
  a_reinit_once: assert property (periph_reinit |=> !periph_reinit)
    else $error("reinit pulse long");
  a_reboot_why: assert property (reboot_pulse |-> $past(clr) || $past(clr, 2))
    else $error("reboot without clear");
  a_init_fall: assert property ($fell(init_done) && !$past(reset) |-> $past(clr) || $past(clr, 2))
    else $error("init done dropped");
  a_init_bound: assert property (!init_done |-> low_cnt_ff <= INIT_HI)
    else $error("init too long");
  a_init_rise: assert property ($rose(init_done) |-> low_cnt_ff >= INIT_LO)
    else $error("init too short");
endmodule // pis_top_chk

bind pis_top pis_top_chk pis_top_chk_i (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .field_sense_pads(field_sense_pads), .out_contacts(out_contacts), .fault_lamp(fault_lamp),
  .periph_reinit(periph_reinit), .reboot_pulse(reboot_pulse), .init_done(init_done)
);

// file: pis_field_model.sv
`timescale 1ns/1ns

module pis_field_model (
  input  wire       clk_sys,
  input  wire [7:0] sw_cmd,
  input  wire [7:0] out_contacts,
  output reg  [7:0] field_sense_pads,
  output reg  [7:0] load_on
);
  // Switches settle one clock after being commanded, like a real contact
  initial field_sense_pads = 8'h00;
  always @(posedge clk_sys) begin
    field_sense_pads <= sw_cmd;
    load_on          <= out_contacts;
  end
endmodule // pis_field_model

// file: pis_top_tb.sv
`timescale 1ns/1ns
`include "pis_regs.vh"

module pis_top_tb;
  reg         clk_sys, reset, psel, penable, pwrite, err, s_ri, s_rb;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg  [7:0]  sw_cmd, prev;
  reg  [15:0] rows [0:3];
  wire [31:0] prdata;
  wire        pready, pslverr, fault_lamp, periph_reinit, reboot_pulse, init_done;
  wire [7:0]  field_sense_pads, out_contacts, load_on;
  integer     n_errors, compares, i, k;

  pis_top pis_top_i (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .field_sense_pads(field_sense_pads), .out_contacts(out_contacts), .fault_lamp(fault_lamp),
    .periph_reinit(periph_reinit), .reboot_pulse(reboot_pulse), .init_done(init_done));
  pis_field_model pis_field_model_i (.clk_sys(clk_sys), .sw_cmd(sw_cmd), .out_contacts(out_contacts),
    .field_sense_pads(field_sense_pads), .load_on(load_on));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ----
  // Bus and check helpers
  // ----
  task check(input [31:0] seen, input [31:0] exp, input string name);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Leaves psel up so a following transfer can start back to back
  task xfer(input [11:0] a, input w, input [31:0] d);
    integer n;
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) n_errors++;
    rd  = prdata;
    err = pslverr;
  endtask

  task idle;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task wr(input [11:0] a, input [31:0] d);
    xfer(a, 1'b1, d);
    idle;
  endtask

  task rdc(input [11:0] a, input [31:0] m, input [31:0] exp, input string name);
    xfer(a, 1'b0, 32'h0000_0000);
    idle;
    check(rd & m, exp, name);
  endtask

  task settle;
    repeat (3) @(posedge clk_sys);
  endtask

  task wait_init;
    integer n;
    n = 0;
    while (init_done !== 1'b1 && n < 1400) begin
      @(posedge clk_sys);
      n++;
    end
    check(init_done, 32'h0000_0001, "init_done");
  endtask

  task pulses;
    s_ri = 1'b0;
    s_rb = 1'b0;
    repeat (4) begin
      s_ri = s_ri | (periph_reinit === 1'b1);
      s_rb = s_rb | (reboot_pulse === 1'b1);
      @(posedge clk_sys);
    end
  endtask

  task complete_run;
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (12000) @(posedge clk_sys);
    n_errors++;
    complete_run;
  end

  // ----
  // Main sequence: pad levels beside the coil values they go out with
  // ----
  initial begin
    n_errors = 0;
    compares = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    sw_cmd = 8'h00;
    prev = 8'h00;
    rows[0] = 16'hA55A;
    rows[1] = 16'h3CC3;
    rows[2] = 16'hFF00;
    rows[3] = 16'h00FF;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    check(out_contacts, 32'h0000_0000, "contacts");
    wait_init;
    rdc(`PIS_ADDR_SCAN_CTRL, 32'hFFFF_0003, 32'h0000_0002, "scan");
    for (i = 0; i < 4; i++) begin
      sw_cmd <= rows[i][15:8];
      for (k = 0; k < 8; k++)
        wr(`PIS_ADDR_OUT_COIL, {23'h0, rows[i][k], 5'h0, k[2:0]});
      check(out_contacts, prev, "held");
      wr(`PIS_ADDR_SCAN_CTRL, 32'h0000_0001);
      settle;
      check(out_contacts, rows[i][7:0], "contacts");
      check(load_on, rows[i][7:0], "load");
      rdc(`PIS_ADDR_IN_IMAGE, 32'h0000_00FF, rows[i][15:8], "image");
      prev = rows[i][7:0];
    end
    sw_cmd <= 8'h96;
    settle;
    for (k = 0; k < 8; k++)
      wr(`PIS_ADDR_IRQ_SERVICE, k);
    rdc(`PIS_ADDR_SPECIAL, 32'h0000_01FF, 32'h0000_0196, "snapshot");
    rdc(`PIS_ADDR_IN_IMAGE, 32'h0000_00FF, 32'h0000_0000, "image");
    sw_cmd <= 8'h00;
    xfer(`PIS_ADDR_OUT_COIL, 1'b1, 32'h0000_0103);
    xfer(`PIS_ADDR_OUT_COIL, 1'b1, 32'h0000_0003);
    idle;
    wr(`PIS_ADDR_SCAN_CTRL, 32'h0000_0001);
    settle;
    check(out_contacts, 32'h0000_00F7, "last coil");
    wr(`PIS_ADDR_SPECIAL, 32'h0000_0300);
    settle;
    check(fault_lamp, 32'h0000_0001, "lamp");
    wr(`PIS_ADDR_SPECIAL, 32'h0000_0100);
    settle;
    check(fault_lamp, 32'h0000_0000, "lamp");
    wr(`PIS_ADDR_LABEL, 32'h0005_001F);
    rdc(`PIS_ADDR_LABEL, 32'hFFFF_0000, 32'h0005_0000, "label");
    wr(`PIS_ADDR_JUMP, 32'h0000_001F);
    rdc(`PIS_ADDR_SCAN_CTRL, 32'hFFFF_0000, 32'h0005_0000, "line");
    wr(`PIS_ADDR_SCAN_CTRL, 32'h0000_0002);
    rdc(`PIS_ADDR_SCAN_CTRL, 32'hFFFF_0000, 32'h0006_0000, "step");
    for (k = 0; k < 4; k++)
      wr(`PIS_ADDR_RELAY_BASE + {k[9:0], 2'b00}, {16'hC3A5, k[15:0]});
    for (k = 0; k < 4; k++)
      rdc(`PIS_ADDR_RELAY_BASE + {k[9:0], 2'b00}, 32'hFFFF_FFFF, {16'hC3A5, k[15:0]}, "relay");
    xfer(12'h01C, 1'b0, 32'h0000_0000);
    idle;
    check(err, 32'h0000_0001, "slverr");
    check(rd, 32'h0000_0000, "rdata");
    wr(`PIS_ADDR_SPECIAL, 32'h0000_0000);
    pulses;
    check(s_ri, 32'h0000_0001, "reinit");
    check(init_done, 32'h0000_0000, "init_done");
    wait_init;
    wr(`PIS_ADDR_SPECIAL, 32'h0000_0500);
    wr(`PIS_ADDR_SPECIAL, 32'h0000_0400);
    pulses;
    check(s_rb, 32'h0000_0001, "reboot");
    check(out_contacts, 32'h0000_0000, "contacts");
    rdc(`PIS_ADDR_RELAY_BASE, 32'hFFFF_FFFF, 32'h0000_0000, "relay");
    wait_init;
    complete_run;
  end
endmodule // pis_top_tb
